/* File: wtc_top.sv */
// Watchdog, periodic tick, clock monitor reset control and slow divider register
// Function
// (R01) Watchdog timeout from three-bit rate, zero off
// (R02) Free-running prescaler gives E over 2^13
// (R03) Unserviced watchdog timeout requests system reset
// (R04) Service is 0x55 then 0xAA write
// (R05) Other accesses allowed between both service writes
// (R06) Any other service value resets immediately
// (R07) Completed service restarts count; register reads zero
// (R08) Tick rate: zero off, else 2^12+code
// (R09) Bypass shortens prescaler to divide by four
// (R10) Tick flag sets on each tick period
// (R11) Writing one clears tick flag
// (R12) Interrupt while flag and enable both set
// (R13) Stop-in-wait halts tick and watchdog
// (R14) Stop-in-debug halts tick and watchdog
// (R15) Some fields write-once in normal modes
// (R16) Test bits locked in normal modes
// (R17) Enabled monitor resets on stalled clock
// (R18) Force-monitor-enable keeps monitor on
// (R19) Force-monitor-reset resets if monitor enabled
// (R20) Force-watchdog-reset resets if watchdog enabled
// (R21) Reset-disable blocks all generated resets
// (R22) Software drops monitor enable around stop
// (R23) Slow divisor is two to field power
// (R24) Slow divider acts only in wait mode
`timescale 1ns/1ps
module wtc_top #(
    parameter int PRESCALE_BITS = wtc_pkg::PRESCALE_BITS_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire wtc_pkg::wtc_addr_t ADDR,
    input wire wtc_pkg::wtc_byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output wtc_pkg::wtc_byte_t RDATA,
    input wire logic WAIT_MODE,
    input wire logic DEBUG_MODE,
    input wire logic SPECIAL_MODE,
    input wire logic CLK_STALL_IN,
    output logic WDOG_RESET,
    output logic CLKMON_RESET,
    output logic TICK_IRQ,
    output wtc_pkg::wtc_sel_t SLOW_DIV_SEL
);
    import wtc_pkg::*;

    // Mask with the n lowest bits set
    function automatic logic [WD_CNT_W-1:0] low_ones(input int n);
        logic [WD_CNT_W-1:0] m;
        m = '0;
        for (int i = 0; i < WD_CNT_W; i++) begin
            m[i] = (i < n);
        end
        return m;
    endfunction

    // Extra powers of two behind the prescaler per watchdog rate code
    function automatic int wd_extra(input wtc_sel_t code);
        int e;
        e = 0;
        unique case (code)
            3'h1: e = 0;
            3'h2: e = 2;
            3'h3: e = 4;
            3'h4: e = 6;
            3'h5: e = 8;
            3'h6: e = 9;
            3'h7: e = 10;
            3'h0: e = 0;
        endcase
        return e;
    endfunction

    wtc_tick_ctl_t tick_ctl_q;
    wtc_wd_ctl_t wd_ctl_q;
    wtc_sel_t slow_sel_q;
    logic tick_once_q;
    logic wd_once_q;
    logic tick_flag_q;
    logic armed_q;
    logic [PRESCALE_BITS-1:0] pre_q;
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic stall_s1_q;
    logic stall_s2_q;
    logic stall_s3_q;
    logic stall_seen_q;
    wtc_rst_req_t rst_q;
    logic irq_q;
    wtc_byte_t rdata_q;

    logic wr_tick_ctl;
    logic wr_tick_flg;
    logic wr_wd_ctl;
    logic wr_wd_svc;
    logic wr_slow;
    logic halted;
    logic base_tick;
    logic tick_evt;
    logic wd_enabled;
    logic wd_timeout;
    logic svc_done;
    logic svc_bad;
    logic mon_active;
    logic [WD_CNT_W-1:0] wd_mask;
    logic [TICK_CNT_W-1:0] tick_mask;
    wtc_tick_ctl_t tick_wr;
    wtc_wd_ctl_t wd_wr;

    assign wr_tick_ctl = WR && (ADDR == ADDR_TICK_CTL);
    assign wr_tick_flg = WR && (ADDR == ADDR_TICK_FLG);
    assign wr_wd_ctl = WR && (ADDR == ADDR_WD_CTL);
    assign wr_wd_svc = WR && (ADDR == ADDR_WD_SVC);
    assign wr_slow = WR && (ADDR == ADDR_SLOW_DIV);
    assign tick_wr = wtc_tick_ctl_t'(WDATA);
    assign wd_wr = wtc_wd_ctl_t'(WDATA);

    // (R13) (R14) Halt both timers in wait or debug
    assign halted = (tick_ctl_q.stop_in_wait && WAIT_MODE) || (tick_ctl_q.stop_in_debug && DEBUG_MODE);

    // (R02) (R09) Prescaler terminal count, bypassed to four
    assign base_tick = tick_ctl_q.divider_bypass ? (&pre_q[BYPASS_BITS-1:0]) : (&pre_q);

    // (R08) Tick period 2^(12+code) of E
    assign tick_mask = TICK_CNT_W'(low_ones(int'(tick_ctl_q.tick_rate_sel) - 1));
    assign tick_evt = base_tick && !halted && (tick_ctl_q.tick_rate_sel != 3'h0)
        && ((tick_cnt_q & tick_mask) == tick_mask);

    // (R01) Watchdog rate selection
    assign wd_enabled = (wd_ctl_q.watchdog_rate_sel != 3'h0);
    assign wd_mask = low_ones(wd_extra(wd_ctl_q.watchdog_rate_sel));
    // (R03) Timeout when enabled and counted out
    assign wd_timeout = wd_enabled && base_tick && !halted && ((wd_cnt_q & wd_mask) == wd_mask);

    // (R04) (R07) Second key after the first completes service
    assign svc_done = wr_wd_svc && (WDATA == SVC_KEY_FIRE) && armed_q;
    // (R06) Any other key is a fault
    assign svc_bad = wr_wd_svc && (WDATA != SVC_KEY_ARM) && (WDATA != SVC_KEY_FIRE);

    // (R18) Forced enable overrides the plain enable
    assign mon_active = wd_ctl_q.monitor_enable || wd_ctl_q.force_monitor_enable;

    // Free-running prescaler, frozen only by halt
    always_ff @(posedge CLK) begin
        if (RST) begin
            pre_q <= '0;
        end else if (!halted) begin
            // (R02) Counts E cycles without restart on service
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_cnt_q <= '0;
        end else if (base_tick && !halted) begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wd_cnt_q <= '0;
        end else if (svc_done) begin
            // (R07) Restart count on completed service
            wd_cnt_q <= '0;
        end else if (base_tick && !halted) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    // (R04) (R05) Arm on first key; other accesses leave it armed
    always_ff @(posedge CLK) begin
        if (RST) begin
            armed_q <= 1'b0;
        end else if (wr_wd_svc) begin
            armed_q <= (WDATA == SVC_KEY_ARM);
        end
    end

    // Tick control: enable and rate anytime, stop bits once, bypass special only
    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_ctl_q <= wtc_tick_ctl_t'(TICK_CTL_RST);
            tick_once_q <= 1'b0;
        end else if (wr_tick_ctl) begin
            tick_once_q <= 1'b1;
            tick_ctl_q.tick_irq_enable <= tick_wr.tick_irq_enable;
            tick_ctl_q.tick_rate_sel <= tick_wr.tick_rate_sel;
            // (R15) Write-once stop bits in normal modes
            if (SPECIAL_MODE || !tick_once_q) begin
                tick_ctl_q.stop_in_wait <= tick_wr.stop_in_wait;
                tick_ctl_q.stop_in_debug <= tick_wr.stop_in_debug;
            end
            // (R16) Bypass writable only in special modes
            if (SPECIAL_MODE) begin
                tick_ctl_q.divider_bypass <= tick_wr.divider_bypass;
            end
        end
    end

    // Watchdog control: monitor enable anytime, others once or special only
    always_ff @(posedge CLK) begin
        if (RST) begin
            wd_ctl_q <= wtc_wd_ctl_t'(WD_CTL_RST);
            wd_once_q <= 1'b0;
        end else if (wr_wd_ctl) begin
            wd_once_q <= 1'b1;
            wd_ctl_q.monitor_enable <= wd_wr.monitor_enable;
            // (R15) (R18) Forced enable sticks until reset in normal modes
            if (SPECIAL_MODE || !wd_once_q) begin
                wd_ctl_q.force_monitor_enable <= wd_wr.force_monitor_enable;
                wd_ctl_q.watchdog_rate_sel <= wd_wr.watchdog_rate_sel;
            end
            // (R16) Test bits writable only in special modes
            if (SPECIAL_MODE) begin
                wd_ctl_q.force_monitor_reset <= wd_wr.force_monitor_reset;
                wd_ctl_q.force_watchdog_reset <= wd_wr.force_watchdog_reset;
                wd_ctl_q.reset_disable <= wd_wr.reset_disable;
            end
        end
    end

    // (R23) Slow divisor select, stored freely
    always_ff @(posedge CLK) begin
        if (RST) begin
            slow_sel_q <= SLOW_DIV_RST[2:0];
        end else if (wr_slow) begin
            slow_sel_q <= WDATA[SLOW_SEL_LSB +: 3];
        end
    end

    // (R10) (R11) Set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_flag_q <= 1'b0;
        end else if (tick_evt) begin
            tick_flag_q <= 1'b1;
        end else if (wr_tick_flg && WDATA[TICK_FLAG_BIT]) begin
            tick_flag_q <= 1'b0;
        end
    end

    // (R12) Registered interrupt request
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= tick_flag_q && tick_ctl_q.tick_irq_enable;
        end
    end

    // Stall detector output arrives from the self-timed delay cell, not this clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            stall_s1_q <= 1'b0;
            stall_s2_q <= 1'b0;
            stall_s3_q <= 1'b0;
        end else begin
            stall_s1_q <= CLK_STALL_IN;
            stall_s2_q <= stall_s1_q;
            stall_s3_q <= stall_s2_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            stall_seen_q <= 1'b0;
        end else if (stall_s2_q == stall_s3_q) begin
            stall_seen_q <= stall_s3_q;
        end
    end

    // Reset requests, one flop deep; the system reset clears them
    always_ff @(posedge CLK) begin
        if (RST) begin
            rst_q <= '0;
        end else begin
            // (R03) (R06) (R20) (R21) Watchdog reset sources
            rst_q.watchdog <= !wd_ctl_q.reset_disable && (wd_timeout || svc_bad
                || (wd_ctl_q.force_watchdog_reset && wd_enabled));
            // (R17) (R19) (R21) Monitor reset sources
            rst_q.monitor <= !wd_ctl_q.reset_disable && mon_active
                && (stall_seen_q || wd_ctl_q.force_monitor_reset);
        end
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= ZERO_BYTE;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_TICK_CTL: rdata_q <= wtc_byte_t'(tick_ctl_q) & 8'hEF;
                ADDR_TICK_FLG: rdata_q <= {tick_flag_q, 7'h00};
                ADDR_WD_CTL: rdata_q <= wtc_byte_t'(wd_ctl_q);
                // (R07) Service register always reads zero
                ADDR_WD_SVC: rdata_q <= ZERO_BYTE;
                ADDR_SLOW_DIV: rdata_q <= {5'h00, slow_sel_q};
                default: rdata_q <= ZERO_BYTE;
            endcase
        end else begin
            rdata_q <= ZERO_BYTE;
        end
    end

    // (R24) Divider only acts in wait mode; zero means bypass
    always_ff @(posedge CLK) begin
        if (RST) begin
            SLOW_DIV_SEL <= 3'h0;
        end else begin
            SLOW_DIV_SEL <= WAIT_MODE ? slow_sel_q : 3'h0;
        end
    end

    assign RDATA = rdata_q;
    assign WDOG_RESET = rst_q.watchdog;
    assign CLKMON_RESET = rst_q.monitor;
    assign TICK_IRQ = irq_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // (R06) Bad key gives reset next cycle
    chk_bad_key_reset: assert property ( // (R06)
        svc_bad && !wd_ctl_q.reset_disable |=> WDOG_RESET)
        else $error("bad service key did not reset");

    // (R21) Disable suppresses both resets
    chk_disable_blocks: assert property ( // (R21)
        $past(wd_ctl_q.reset_disable) |-> !WDOG_RESET && !CLKMON_RESET)
        else $error("reset raised while resets disabled");

    // (R12) No request without enable
    chk_irq_gated: assert property ( // (R12)
        !tick_ctl_q.tick_irq_enable ##1 !tick_ctl_q.tick_irq_enable |-> !TICK_IRQ)
        else $error("tick interrupt with enable clear");

    // (R10) Flag follows every tick event
    chk_flag_sets: assert property ( // (R10)
        tick_evt |=> tick_flag_q ##1 (tick_flag_q || $past(wr_tick_flg)))
        else $error("tick flag not set by event");

    // (R11) Write of one clears flag when no event
    chk_flag_clears: assert property ( // (R11)
        wr_tick_flg && WDATA[TICK_FLAG_BIT] && !tick_evt |=> !tick_flag_q)
        else $error("tick flag not cleared");

    // (R13) (R14) Halt freezes prescaler and watchdog count
    chk_halt_freeze: assert property ( // (R13)
        halted && !svc_done |=> pre_q == $past(pre_q) && wd_cnt_q == $past(wd_cnt_q))
        else $error("timers moved while halted");

    // (R15) Rate locked after first write in normal mode
    chk_rate_once: assert property ( // (R15)
        wr_wd_ctl && wd_once_q && !SPECIAL_MODE |=> $stable(wd_ctl_q.watchdog_rate_sel))
        else $error("watchdog rate changed after first write");

    // (R16) Test bits ignore normal-mode writes
    chk_test_locked: assert property ( // (R16)
        WR && !SPECIAL_MODE |=> $stable(wd_ctl_q.reset_disable) && $stable(tick_ctl_q.divider_bypass))
        else $error("test bit written in normal mode");

    // (R07) Completed service restarts the count
    chk_service_restart: assert property ( // (R07)
        $rose(armed_q) ##[1:8] svc_done |=> wd_cnt_q == '0)
        else $error("service did not restart count");

    // (R01) Rate zero raises a watchdog reset only from a bad service key
    chk_rate_off: assert property ( // (R01)
        wd_ctl_q.watchdog_rate_sel == 3'h0 && !wr_wd_svc |=> !WDOG_RESET)
        else $error("watchdog reset with watchdog off");

    // (R24) Divider off outside wait
    chk_slow_wait_only: assert property ( // (R24)
        !WAIT_MODE |=> SLOW_DIV_SEL == 3'h0)
        else $error("slow divider active outside wait");

    // (R19) Forced monitor reset with monitor on
    chk_force_monitor: assert property ( // (R19)
        wd_ctl_q.force_monitor_reset && mon_active && !wd_ctl_q.reset_disable |=> CLKMON_RESET)
        else $error("forced monitor reset missing");

    cov_service: cover property (wr_wd_svc && WDATA == SVC_KEY_ARM ##[1:8] svc_done);
    cov_timeout: cover property (wd_timeout ##1 WDOG_RESET);
    cov_tick_irq: cover property (tick_evt ##2 TICK_IRQ);
    cov_set_clear: cover property (tick_evt && wr_tick_flg && WDATA[TICK_FLAG_BIT]);
endmodule

/* File: wtc_pkg.sv */
// Package: register map, field layouts and constants for the watchdog/tick/monitor block
package wtc_pkg;

    typedef logic [7:0] wtc_addr_t;
    typedef logic [7:0] wtc_byte_t;
    typedef logic [2:0] wtc_sel_t;

    // Register byte offsets within the block
    localparam wtc_addr_t ADDR_TICK_CTL = 8'h14;
    localparam wtc_addr_t ADDR_TICK_FLG = 8'h15;
    localparam wtc_addr_t ADDR_WD_CTL = 8'h16;
    localparam wtc_addr_t ADDR_WD_SVC = 8'h17;
    localparam wtc_addr_t ADDR_SLOW_DIV = 8'hE0;

    // Service sequence keys
    localparam wtc_byte_t SVC_KEY_ARM = 8'h55;
    localparam wtc_byte_t SVC_KEY_FIRE = 8'hAA;

    // Bit positions
    localparam int TICK_FLAG_BIT = 7;
    localparam int SLOW_SEL_LSB = 0;

    // Prescaler lengths: normal chain and bypassed chain (in flip-flop stages)
    localparam int PRESCALE_BITS_DEF = 13;
    localparam int BYPASS_BITS = 2;
    // Extra division counters behind the prescaler
    localparam int WD_CNT_W = 10;
    localparam int TICK_CNT_W = 6;

    // Tick control register layout, MSB first
    typedef struct packed {
        logic tick_irq_enable;
        logic stop_in_wait;
        logic stop_in_debug;
        logic unused4;
        logic divider_bypass;
        wtc_sel_t tick_rate_sel;
    } wtc_tick_ctl_t;

    // Watchdog control register layout, MSB first
    typedef struct packed {
        logic monitor_enable;
        logic force_monitor_enable;
        logic force_monitor_reset;
        logic force_watchdog_reset;
        logic reset_disable;
        wtc_sel_t watchdog_rate_sel;
    } wtc_wd_ctl_t;

    // Reset values
    localparam wtc_byte_t TICK_CTL_RST = 8'h00;
    localparam wtc_byte_t WD_CTL_RST = 8'h01;
    localparam wtc_byte_t SLOW_DIV_RST = 8'h00;
    localparam wtc_byte_t ZERO_BYTE = 8'h00;

    // Reset request outputs
    typedef struct packed {
        logic watchdog;
        logic monitor;
    } wtc_rst_req_t;

endpackage

/* File: test_wtc_top.sv */
// Self-checking testbench for the watchdog, tick and clock monitor block
`timescale 1ns/1ps
module test_wtc_top;
    import wtc_pkg::*;
    // Short prescaler keeps every timeout within a few thousand cycles
    localparam int PB = 4;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    wtc_addr_t ADDR = 8'h00;
    wtc_byte_t WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic WAIT_MODE = 1'b0;
    logic DEBUG_MODE = 1'b0;
    logic SPECIAL_MODE = 1'b0;
    logic CLK_STALL_IN = 1'b0;
    wtc_byte_t RDATA;
    logic WDOG_RESET;
    logic CLKMON_RESET;
    logic TICK_IRQ;
    wtc_sel_t SLOW_DIV_SEL;
    wtc_byte_t exp_q[$];
    logic rd_pend = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int wd_exp[6] = '{0, 2, 4, 6, 8, 9};

    wtc_top #(.PRESCALE_BITS(PB)) dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .WAIT_MODE(WAIT_MODE), .DEBUG_MODE(DEBUG_MODE), .SPECIAL_MODE(SPECIAL_MODE),
        .CLK_STALL_IN(CLK_STALL_IN), .WDOG_RESET(WDOG_RESET), .CLKMON_RESET(CLKMON_RESET),
        .TICK_IRQ(TICK_IRQ), .SLOW_DIV_SEL(SLOW_DIV_SEL));

    always #10 CLK = ~CLK;

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_read(input wtc_byte_t got, input wtc_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: read %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    function automatic logic out_bit(input int sel);
        case (sel)
            0: return WDOG_RESET;
            1: return CLKMON_RESET;
            default: return TICK_IRQ;
        endcase
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic wr(input wtc_addr_t a, input wtc_byte_t d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask

    // Read data is checked one cycle later by the monitor below
    task automatic rd(input wtc_addr_t a, input wtc_byte_t exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(exp);
        @(posedge CLK);
        RD <= 1'b0;
        #1;
    endtask

    always @(negedge CLK) begin
        if (rd_pend) begin
            check_read(RDATA, exp_q.pop_front());
        end
        rd_pend = RD;
    end

    task automatic wait_hi(input int sel, input int bound);
        int n;
        n = 0;
        while (out_bit(sel) !== 1'b1) begin
            if (n == bound) begin
                check_num(32'h0, 32'h1);
                give_verdict();
            end
            step(1);
            n++;
        end
    endtask

    task automatic quiet(input int sel, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            step(1);
            seen = seen | (out_bit(sel) !== 1'b0);
        end
        check_num(seen, 0);
    endtask

    // Rise-to-rise distance; the tick flag is cleared in between
    task automatic measure(input int sel, input int exp);
        int n;
        n = 0;
        wait_hi(sel, 2 * exp + 8);
        if (sel == 2) begin
            wr(ADDR_TICK_FLG, 8'h80);
            n = 2;
        end
        while (out_bit(sel) !== 1'b0 && n < 2 * exp) begin
            step(1);
            n++;
        end
        while (out_bit(sel) !== 1'b1 && n < 2 * exp) begin
            step(1);
            n++;
        end
        check_num(n, exp);
    endtask

    initial begin
        wtc_byte_t k;
        void'($urandom(32'hE865E0F1));
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        // Watchdog runs from reset, so it is stopped before the other reads
        rd(ADDR_WD_CTL, WD_CTL_RST);
        wr(ADDR_WD_CTL, 8'h00);
        rd(ADDR_TICK_CTL, TICK_CTL_RST);
        rd(ADDR_TICK_FLG, ZERO_BYTE);
        rd(ADDR_WD_SVC, ZERO_BYTE);
        rd(ADDR_SLOW_DIV, SLOW_DIV_RST);
        rd(8'h3C, ZERO_BYTE);
        wr(ADDR_WD_CTL, 8'h9F);
        rd(ADDR_WD_CTL, 8'h80);
        wr(ADDR_TICK_CTL, 8'h48);
        wr(ADDR_TICK_CTL, 8'h87);
        rd(ADDR_TICK_CTL, 8'hC7);
        end_test("reset and locks");
        @(posedge CLK);
        SPECIAL_MODE <= 1'b1;
        for (int c = 1; c < 8; c++) begin
            wr(ADDR_TICK_CTL, 8'h80 | c[7:0]);
            wr(ADDR_TICK_FLG, 8'h80);
            step(3);
            measure(2, 1 << (PB + c - 1));
        end
        wr(ADDR_TICK_CTL, 8'h8B);
        wr(ADDR_TICK_FLG, 8'h80);
        step(3);
        measure(2, 16);
        wr(ADDR_TICK_CTL, 8'h01);
        step(3);
        quiet(2, 40);
        wr(ADDR_TICK_CTL, 8'h00);
        rd(ADDR_TICK_FLG, 8'h80);
        wr(ADDR_TICK_FLG, 8'h00);
        rd(ADDR_TICK_FLG, 8'h80);
        wr(ADDR_TICK_FLG, 8'h80);
        rd(ADDR_TICK_FLG, 8'h00);
        wr(ADDR_TICK_CTL, 8'h80);
        quiet(2, 100);
        end_test("tick");
        for (int m = 0; m < 2; m++) begin
            @(posedge CLK);
            WAIT_MODE <= (m == 0);
            DEBUG_MODE <= (m == 1);
            wr(ADDR_TICK_CTL, (m == 0) ? 8'hC1 : 8'hA1);
            wr(ADDR_WD_CTL, 8'h01);
            wr(ADDR_TICK_FLG, 8'h80);
            step(3);
            quiet(0, 100);
            quiet(2, 100);
            @(posedge CLK);
            WAIT_MODE <= 1'b0;
            DEBUG_MODE <= 1'b0;
            wait_hi(2, 40);
            wr(ADDR_WD_CTL, 8'h00);
        end
        wr(ADDR_TICK_CTL, 8'h00);
        end_test("halt");
        for (int c = 1; c < 7; c++) begin
            wr(ADDR_WD_CTL, c[7:0]);
            measure(0, 1 << (PB + wd_exp[c - 1]));
            wr(ADDR_WD_CTL, 8'h00);
        end
        wr(ADDR_WD_SVC, SVC_KEY_ARM);
        wr(ADDR_WD_SVC, SVC_KEY_FIRE);
        wr(ADDR_WD_CTL, 8'h03);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_WD_SVC, SVC_KEY_ARM);
            wr(8'h40 + 8'($urandom_range(15)), 8'($urandom));
            rd(ADDR_WD_SVC, ZERO_BYTE);
            wr(ADDR_WD_SVC, SVC_KEY_FIRE);
            quiet(0, 90);
        end
        wait_hi(0, 300);
        wr(ADDR_WD_CTL, 8'h00);
        step(2);
        end_test("watchdog");
        for (int i = 0; i < 4; i++) begin
            k = 8'($urandom);
            if (k == SVC_KEY_ARM || k == SVC_KEY_FIRE) begin
                k = 8'h00;
            end
            wr(ADDR_WD_SVC, k);
            check_num(WDOG_RESET, 1);
            step(1);
            check_num(WDOG_RESET, 0);
        end
        wr(ADDR_WD_SVC, SVC_KEY_FIRE);
        quiet(0, 5);
        wr(ADDR_WD_CTL, 8'h08);
        wr(ADDR_WD_SVC, 8'h33);
        quiet(0, 5);
        wr(ADDR_WD_CTL, 8'h17);
        wait_hi(0, 3);
        wr(ADDR_WD_CTL, 8'h1F);
        step(2);
        quiet(0, 20);
        wr(ADDR_WD_CTL, 8'h10);
        step(2);
        quiet(0, 20);
        end_test("forced watchdog");
        wr(ADDR_WD_CTL, 8'h80);
        @(posedge CLK);
        CLK_STALL_IN <= 1'b1;
        wait_hi(1, 10);
        wr(ADDR_WD_CTL, 8'h00);
        step(2);
        quiet(1, 10);
        wr(ADDR_WD_CTL, 8'h40);
        wait_hi(1, 4);
        wr(ADDR_WD_CTL, 8'h48);
        step(2);
        quiet(1, 10);
        @(posedge CLK);
        CLK_STALL_IN <= 1'b0;
        wr(ADDR_WD_CTL, 8'hA0);
        wait_hi(1, 10);
        wr(ADDR_WD_CTL, 8'h20);
        step(2);
        quiet(1, 10);
        wr(ADDR_WD_CTL, 8'h00);
        end_test("clock monitor");
        @(posedge CLK);
        WAIT_MODE <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_SLOW_DIV, c[7:0]);
            step(1);
            check_num(SLOW_DIV_SEL, c);
        end
        rd(ADDR_SLOW_DIV, 8'h07);
        @(posedge CLK);
        WAIT_MODE <= 1'b0;
        step(2);
        check_num(SLOW_DIV_SEL, 0);
        end_test("slow divider");
        step(3);
        give_verdict();
    end
endmodule
